//--- logic/ref_pulse_pkg.sv
// Constants, register map and encodings for the reference pulse input decoder
package ref_pulse_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFS_CONFIG    = 8'h00;
  localparam logic [7:0] OFS_GEAR_ONE  = 8'h04;
  localparam logic [7:0] OFS_GEAR_TWO  = 8'h08;
  localparam logic [7:0] OFS_CONTROL   = 8'h0c;
  localparam logic [7:0] OFS_ACTIVE    = 8'h10;
  localparam logic [7:0] OFS_POS_ERROR = 8'h14;
  localparam logic [7:0] OFS_FEEDBACK  = 8'h18;

  // Field positions in the configuration, active configuration and control words
  localparam int FMT_LSB     = 0;
  localparam int INV_LSB     = 4;
  localparam int CLR_LSB     = 8;
  localparam int ENC_BIT     = 12;
  localparam int RESTART_BIT = 0;

  // Bits of the inversion field
  localparam int INV_DIR_IDX   = 0;
  localparam int INV_PULSE_IDX = 1;

  // Widths and reset values
  localparam int          GEAR_W       = 16;
  localparam logic [31:0] CONFIG_RST   = 32'h0000_0000;
  localparam logic [15:0] GEAR_RST     = 16'h0001;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
  localparam logic [15:0] GEAR_PAD     = 16'h0000;

  // Pulse format encodings
  typedef enum logic [2:0] {
    FMT_SIGN_PULSE = 3'h0,
    FMT_CW_CCW     = 3'h1,
    FMT_QUAD_X1    = 3'h2,
    FMT_QUAD_X2    = 3'h3,
    FMT_QUAD_X4    = 3'h4
  } pulse_format_t;

  // Error count clearing encodings
  typedef enum logic [1:0] {
    CLR_SERVO_OFF  = 2'h0,
    CLR_NEVER      = 2'h1,
    CLR_OFF_OR_OT  = 2'h2
  } error_clear_t;

endpackage

//--- logic/reference_pulse_input_decoder.sv
// Reference pulse train decoder with gearing, error count and APB registers
// Functional notes
// RULE1 - The format setting picks sign plus pulse, CW/CCW lines, or quadrature at x1, x2 or x4.
// RULE2 - The inversion setting flips the direction line, the pulse line, neither or both.
// RULE3 - Error count clears on servo off, never, or on servo off or overtravel outside zero clamp.
// RULE4 - Proportional control input active selects gear numerator two, else numerator one.
// RULE5 - Encoder use setting keeps absolute position or reports counts relative to restart.
// RULE6 - Format, inversion and clear settings take effect only at a restart.
`timescale 1ns/1ps
module reference_pulse_input_decoder (
  input  logic        clock,
  input  logic        reset,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  logic        pulseLine,
  input  logic        directionLine,
  input  logic        proportionalControlInput,
  input  logic        servoOn,
  input  logic        overtravel,
  input  logic        zeroClamp,
  input  logic [31:0] encoderPosition,
  output logic [31:0] positionError,
  output logic [31:0] feedbackPosition
);

  logic [31:0] config_ff;
  logic [15:0] gearOne_ff;
  logic [15:0] gearTwo_ff;
  logic [2:0]  sync1_ff;
  logic [2:0]  sync2_ff;
  logic        prevA_ff;
  logic        prevB_ff;
  logic        startPending_ff;
  logic [2:0]  activeFmt_ff;
  logic [1:0]  activeInv_ff;
  logic [1:0]  activeClr_ff;
  logic        activeEnc_ff;
  logic [31:0] baseline_ff;
  logic [31:0] positionError_ff;
  logic [31:0] feedbackPosition_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;

  // Step decode: returns {valid, forward} for one sample of both lines
  function automatic logic [1:0] step_code(input logic [2:0] fmt, input logic aO,
                                           input logic aN, input logic bO, input logic bN);
    logic aRise;
    logic bRise;
    logic aEdge;
    logic bEdge;
    aRise = aN & ~aO;
    bRise = bN & ~bO;
    aEdge = aN ^ aO;
    bEdge = bN ^ bO;
    case (fmt)
      ref_pulse_pkg::FMT_SIGN_PULSE: step_code = {aRise, ~bN};
      ref_pulse_pkg::FMT_CW_CCW:     step_code = {aRise ^ bRise, aRise};
      ref_pulse_pkg::FMT_QUAD_X1:    step_code = {aRise & ~bEdge, ~bO};
      ref_pulse_pkg::FMT_QUAD_X2:    step_code = {aEdge & ~bEdge, aN ^ bO};
      ref_pulse_pkg::FMT_QUAD_X4:    step_code = {aEdge ^ bEdge, aN ^ bO};
      default:                       step_code = 2'h0;
    endcase
  endfunction

  // APB decode; writes land only at the completing access edge
  wire setupPhase = psel & ~penable;
  wire apbWrite   = psel & penable & pready_ff & pwrite;
  wire selConfig  = (paddr == ref_pulse_pkg::OFS_CONFIG);
  wire selGearOne = (paddr == ref_pulse_pkg::OFS_GEAR_ONE);
  wire selGearTwo = (paddr == ref_pulse_pkg::OFS_GEAR_TWO);
  wire selControl = (paddr == ref_pulse_pkg::OFS_CONTROL);
  wire selActive  = (paddr == ref_pulse_pkg::OFS_ACTIVE);
  wire selPosErr  = (paddr == ref_pulse_pkg::OFS_POS_ERROR);
  wire selFeed    = (paddr == ref_pulse_pkg::OFS_FEEDBACK);
  wire mapped     = selConfig | selGearOne | selGearTwo | selControl | selActive
                    | selPosErr | selFeed;
  wire [31:0] activeWord = {19'h0_0000, activeEnc_ff, 2'h0, activeClr_ff, 2'h0,
                            activeInv_ff, 1'h0, activeFmt_ff};
  wire [31:0] readMux = selConfig  ? config_ff :
                        selGearOne ? {ref_pulse_pkg::GEAR_PAD, gearOne_ff} :
                        selGearTwo ? {ref_pulse_pkg::GEAR_PAD, gearTwo_ff} :
                        selActive  ? activeWord :
                        selPosErr  ? positionError_ff :
                        selFeed    ? feedbackPosition_ff : ref_pulse_pkg::ZERO_WORD;

  // Restart is the first cycle after reset release or a software request
  wire restart = startPending_ff
                 | (apbWrite & selControl & pwdata[ref_pulse_pkg::RESTART_BIT]);

  // Bus registers; one-cycle access phase keeps the master simple
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      config_ff  <= ref_pulse_pkg::CONFIG_RST;
      gearOne_ff <= ref_pulse_pkg::GEAR_RST;
      gearTwo_ff <= ref_pulse_pkg::GEAR_RST;
      prdata_ff  <= ref_pulse_pkg::ZERO_WORD;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      if (apbWrite & selConfig)
        config_ff <= pwdata;
      if (apbWrite & selGearOne)
        gearOne_ff <= pwdata[ref_pulse_pkg::GEAR_W-1:0];
      if (apbWrite & selGearTwo)
        gearTwo_ff <= pwdata[ref_pulse_pkg::GEAR_W-1:0];
      pready_ff  <= setupPhase;
      pslverr_ff <= setupPhase & ~mapped;
      if (setupPhase)
        prdata_ff <= readMux;
    end
  end

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end
    else
    begin
      sync1_ff <= {proportionalControlInput, directionLine, pulseLine};
      sync2_ff <= sync1_ff;
    end
  end

  // RULE2 - line inversion
  wire aNew       = sync2_ff[0] ^ activeInv_ff[ref_pulse_pkg::INV_PULSE_IDX];
  wire bNew       = sync2_ff[1] ^ activeInv_ff[ref_pulse_pkg::INV_DIR_IDX];
  wire gearTwoReq = sync2_ff[2];
  // Line levels under the inversion being latched; keeps a restart from faking an edge
  wire aRestart   = sync2_ff[0]
                    ^ config_ff[ref_pulse_pkg::INV_LSB + ref_pulse_pkg::INV_PULSE_IDX];
  wire bRestart   = sync2_ff[1]
                    ^ config_ff[ref_pulse_pkg::INV_LSB + ref_pulse_pkg::INV_DIR_IDX];

  // RULE1 - format decode
  wire [1:0] stepCode = step_code(activeFmt_ff, prevA_ff, aNew, prevB_ff, bNew);
  wire       stepValid = stepCode[1];
  wire       stepFwd   = stepCode[0];

  // RULE4 - gear numerator select
  wire [15:0] gearSel    = gearTwoReq ? gearTwo_ff : gearOne_ff;
  wire [31:0] stepAmount = {ref_pulse_pkg::GEAR_PAD, gearSel};

  // RULE3 - clear conditions; a clear outranks a step in the same cycle
  wire offOrOt  = ~servoOn | overtravel;
  wire errClear = restart
                  | ((activeClr_ff == ref_pulse_pkg::CLR_SERVO_OFF) & ~servoOn)
                  | ((activeClr_ff == ref_pulse_pkg::CLR_OFF_OR_OT) & offOrOt & ~zeroClamp);
  wire [31:0] nxt_positionError = errClear ? ref_pulse_pkg::ZERO_WORD :
                                  ~stepValid ? positionError_ff :
                                  stepFwd ? positionError_ff + stepAmount :
                                            positionError_ff - stepAmount;

  // RULE5 - absolute or incremental feedback
  wire [31:0] nxt_feedbackPosition = activeEnc_ff ? encoderPosition - baseline_ff
                                                  : encoderPosition;

  // RULE6 - settings captured only on restart
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      startPending_ff <= 1'b1;
      activeFmt_ff    <= 3'h0;
      activeInv_ff    <= 2'h0;
      activeClr_ff    <= 2'h0;
      activeEnc_ff    <= 1'b0;
      baseline_ff     <= ref_pulse_pkg::ZERO_WORD;
    end
    else
    begin
      startPending_ff <= 1'b0;
      if (restart)
      begin
        activeFmt_ff <= config_ff[ref_pulse_pkg::FMT_LSB +: 3];
        activeInv_ff <= config_ff[ref_pulse_pkg::INV_LSB +: 2];
        activeClr_ff <= config_ff[ref_pulse_pkg::CLR_LSB +: 2];
        activeEnc_ff <= config_ff[ref_pulse_pkg::ENC_BIT];
        baseline_ff  <= encoderPosition;
      end
    end
  end

  // Counting state; previous line levels held after inversion
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      prevA_ff            <= 1'b0;
      prevB_ff            <= 1'b0;
      positionError_ff    <= ref_pulse_pkg::ZERO_WORD;
      feedbackPosition_ff <= ref_pulse_pkg::ZERO_WORD;
    end
    else
    begin
      prevA_ff            <= restart ? aRestart : aNew;
      prevB_ff            <= restart ? bRestart : bNew;
      positionError_ff    <= nxt_positionError;
      feedbackPosition_ff <= nxt_feedbackPosition;
    end
  end

  assign prdata           = prdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  assign positionError    = positionError_ff;
  assign feedbackPosition = feedbackPosition_ff;

  // Checks on the decoded behaviour
  property p_cw_ccw_down;
    @(posedge clock) disable iff (reset)
    (activeFmt_ff == ref_pulse_pkg::FMT_CW_CCW) && bNew && !prevB_ff && !(aNew && !prevA_ff)
    && !errClear
    |=> positionError_ff == $past(positionError_ff) - $past(stepAmount);
  endproperty
  a_cw_ccw_down: assert property (p_cw_ccw_down) // RULE1
    else $error("CCW pulse did not decrement error count");

  property p_x4_double_edge;
    @(posedge clock) disable iff (reset)
    (activeFmt_ff == ref_pulse_pkg::FMT_QUAD_X4) && (aNew != prevA_ff) && (bNew != prevB_ff)
    && !errClear |=> $stable(positionError_ff);
  endproperty
  a_x4_double_edge: assert property (p_x4_double_edge) // RULE1
    else $error("Quadrature double edge was counted");

  property p_inverted_pulse;
    @(posedge clock) disable iff (reset)
    (activeFmt_ff == ref_pulse_pkg::FMT_SIGN_PULSE) && (activeInv_ff == 2'h2)
    && $fell(sync2_ff[0]) && !errClear |=> positionError_ff != $past(positionError_ff);
  endproperty
  a_inverted_pulse: assert property (p_inverted_pulse) // RULE2
    else $error("Inverted pulse falling edge not counted");

  property p_clear_servo_off;
    @(posedge clock) disable iff (reset)
    (activeClr_ff == ref_pulse_pkg::CLR_SERVO_OFF) && !servoOn ##1 !servoOn
    |-> positionError_ff == ref_pulse_pkg::ZERO_WORD;
  endproperty
  a_clear_servo_off: assert property (p_clear_servo_off) // RULE3
    else $error("Error count not cleared on servo off");

  property p_never_clear;
    @(posedge clock) disable iff (reset)
    (activeClr_ff == ref_pulse_pkg::CLR_NEVER) && !stepValid && !restart
    |=> $stable(positionError_ff);
  endproperty
  a_never_clear: assert property (p_never_clear) // RULE3
    else $error("Error count changed with clearing disabled");

  property p_gear_two;
    @(posedge clock) disable iff (reset)
    stepValid && stepFwd && gearTwoReq && !errClear
    |=> positionError_ff == $past(positionError_ff)
        + {ref_pulse_pkg::GEAR_PAD, $past(gearTwo_ff)};
  endproperty
  a_gear_two: assert property (p_gear_two) // RULE4
    else $error("Second gear numerator not applied");

  property p_absolute_feedback;
    @(posedge clock) disable iff (reset)
    !activeEnc_ff |=> feedbackPosition_ff == $past(encoderPosition);
  endproperty
  a_absolute_feedback: assert property (p_absolute_feedback) // RULE5
    else $error("Absolute feedback not passed through");

  property p_hold_settings;
    @(posedge clock) disable iff (reset)
    !restart |=> $stable(activeFmt_ff) && $stable(activeInv_ff) && $stable(activeClr_ff);
  endproperty
  a_hold_settings: assert property (p_hold_settings) // RULE6
    else $error("Active settings changed without restart");

endmodule

//--- verif/pulse_controller_model.sv
// Behavioural motion controller that drives the reference lines and gear select
`timescale 1ns/1ps
module pulse_controller_model (
  input  wire logic clock,
  output logic      pulseLine,
  output logic      directionLine,
  output logic      proportionalControlInput
);
  initial
  begin
    pulseLine = 1'b0;
    directionLine = 1'b0;
    proportionalControlInput = 1'b0;
  end
  // line levels
  // Five clocks per level, so every level clears the two-clock minimum
  task automatic lines(input logic a, input logic b);
    @(posedge clock);
    pulseLine <= a;
    directionLine <= b;
    repeat (4) @(posedge clock);
  endtask
  task automatic cycle();
    lines(1'b1, 1'b0);
    lines(1'b1, 1'b1);
    lines(1'b0, 1'b1);
    lines(1'b0, 1'b0);
  endtask
  // gear select settling
  // The settle time is shortened from the millisecond to keep runs short
  task automatic gearSel(input logic on);
    @(posedge clock);
    proportionalControlInput <= on;
    repeat (20) @(posedge clock);
  endtask
endmodule

//--- verif/test_reference_pulse_input_decoder.sv
// Self-checking bench for the reference pulse input decoder
`timescale 1ns/1ps
module test_reference_pulse_input_decoder;
  logic        clock;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pulseLine;
  logic        directionLine;
  logic        proportionalControlInput;
  logic        servoOn;
  logic        overtravel;
  logic        zeroClamp;
  logic [31:0] encoderPosition;
  logic [31:0] positionError;
  logic [31:0] feedbackPosition;
  logic [31:0] rd;
  logic        er;
  int          err_total;
  int          check_count;
  // Config words and expected error counts for one forward cycle at gear 3
  logic [31:0] cfgTab [9] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h5, 32'h10, 32'h20, 32'h30};
  logic [31:0] expTab [9] = '{32'h3, 32'h0, 32'h3, 32'h6, 32'hc, 32'h0, 32'hffff_fffd,
                              32'hffff_fffd, 32'h3};

  reference_pulse_input_decoder dut (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulseLine(pulseLine), .directionLine(directionLine),
    .proportionalControlInput(proportionalControlInput), .servoOn(servoOn),
    .overtravel(overtravel), .zeroClamp(zeroClamp), .encoderPosition(encoderPosition),
    .positionError(positionError), .feedbackPosition(feedbackPosition));

  pulse_controller_model ctl (.clock(clock), .pulseLine(pulseLine),
    .directionLine(directionLine), .proportionalControlInput(proportionalControlInput));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Setup then access, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do
    begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic restart(input logic [31:0] cfg);
    apb(1'b1, ref_pulse_pkg::OFS_CONFIG, cfg);
    apb(1'b1, ref_pulse_pkg::OFS_CONTROL, 32'h1);
    repeat (4) @(posedge clock);
  endtask

  // Apply servo state, overtravel and zero clamp, then check the count
  task automatic cond(input logic son, input logic ot, input logic zc, input logic [31:0] exp);
    servoOn <= son;
    overtravel <= ot;
    zeroClamp <= zc;
    repeat (4) @(posedge clock);
    chk32("error under clear condition", exp, positionError);
  endtask

  task automatic wrap_up();
    $display("mismatches %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    err_total++;
    wrap_up();
  end

  initial
  begin
    reset = 1'b1;
    {psel, penable, pwrite, overtravel, zeroClamp} = 5'h00;
    servoOn = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    encoderPosition = 32'h0;
    err_total = 0;
    check_count = 0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    apb(1'b0, ref_pulse_pkg::OFS_CONFIG, 32'h0);
    chk32("config reset", ref_pulse_pkg::CONFIG_RST, rd);
    apb(1'b0, ref_pulse_pkg::OFS_GEAR_TWO, 32'h0);
    chk32("gear two reset", {ref_pulse_pkg::GEAR_PAD, ref_pulse_pkg::GEAR_RST}, rd);
    apb(1'b0, 8'h1c, 32'h0);
    chk1("unmapped error", 1'b1, er);
    apb(1'b1, ref_pulse_pkg::OFS_GEAR_ONE, 32'h3);
    // Every format, then each inversion choice on sign plus pulse
    for (int i = 0; i < 9; i++)
    begin
      restart(cfgTab[i]);
      chk32("error after restart", ref_pulse_pkg::ZERO_WORD, positionError);
      ctl.cycle();
      repeat (4) @(posedge clock);
      chk32("decoded count", expTab[i], positionError);
    end
    // Settings written while running stay inactive until a restart
    apb(1'b1, ref_pulse_pkg::OFS_CONFIG, 32'h4);
    apb(1'b0, ref_pulse_pkg::OFS_ACTIVE, 32'h0);
    chk32("active before restart", 32'h30, rd);
    restart(32'h4);
    apb(1'b0, ref_pulse_pkg::OFS_ACTIVE, 32'h0);
    chk32("active after restart", 32'h4, rd);
    restart(32'h0);
    apb(1'b1, ref_pulse_pkg::OFS_GEAR_TWO, 32'h5);
    ctl.gearSel(1'b1);
    ctl.cycle();
    chk32("gear two count", 32'h5, positionError);
    ctl.gearSel(1'b0);
    ctl.cycle();
    chk32("gear one count", 32'h8, positionError);
    restart(32'h0);
    ctl.cycle();
    cond(1'b1, 1'b1, 1'b0, 32'h3);
    cond(1'b0, 1'b0, 1'b0, 32'h0);
    cond(1'b1, 1'b0, 1'b0, 32'h0);
    restart(32'h100);
    ctl.cycle();
    cond(1'b0, 1'b1, 1'b0, 32'h3);
    cond(1'b1, 1'b0, 1'b0, 32'h3);
    restart(32'h200);
    ctl.cycle();
    cond(1'b1, 1'b1, 1'b1, 32'h3);
    cond(1'b1, 1'b1, 1'b0, 32'h0);
    cond(1'b1, 1'b0, 1'b0, 32'h0);
    encoderPosition <= 32'h64;
    restart(32'h1000);
    encoderPosition <= 32'h96;
    repeat (3) @(posedge clock);
    chk32("incremental feedback", 32'h32, feedbackPosition);
    restart(32'h0);
    chk32("absolute feedback", 32'h96, feedbackPosition);
    wrap_up();
  end
endmodule
